// ==== dv/smcp_host.sv ====
// Host-side serial model: sends framed commands, collects reply characters
`timescale 1ns/1ps
module smcp_host
  import smcp_pkg::*;
#(
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] rx_q [$];
  logic [7:0] sh;

  // Idle line level is the mark state, as a real port leaves it
  initial rxd_o = 1'b1;

  task automatic wait_bits(input int unsigned n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One 8N1 character, low bit first, returning at the end of the stop bit
  task automatic send_byte(input logic [7:0] b);
    rxd_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wait_bits(BIT_CYC_P);
      rxd_o = b[i];
    end
    wait_bits(BIT_CYC_P);
    rxd_o = 1'b1;
    wait_bits(BIT_CYC_P);
  endtask

  // No spaces and no terminator: the closing brace alone ends it
  task automatic send_cmd(input string s);
    send_byte(CH_LBRACE);
    foreach (s[i]) send_byte(s[i]);
    send_byte(CH_RBRACE);
  endtask

  // Receiver samples mid-bit; a bad stop bit drops the character
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC_P / 2) @(posedge clk_i);
    if (txd_i === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC_P) @(posedge clk_i);
        sh[i] = txd_i;
      end
      repeat (BIT_CYC_P) @(posedge clk_i);
      if (txd_i === 1'b1) rx_q.push_back(sh);
    end
  end
endmodule // smcp_host

// ==== dv/smcp_port_tb.sv ====
// Self-checking bench of the serial motion command port
`timescale 1ns/1ps
module smcp_port_tb;
  import smcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxd, txd, ready, cmd_valid, rready, mode_save;
  logic task_done = 1'b0;
  logic rvalid = 1'b0;
  logic rsep = 1'b0;
  logic rlast = 1'b0;
  logic mode_we = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic [1:0] mode_in = 2'h0;
  smcp_class_e cmd_class;
  logic [7:0] cmd_code;
  logic [23:0] fld [6];
  logic [2:0] nf;
  logic [1:0] mode_o;
  logic [4:0] seq_lim;
  int mismatches = 0;
  int tests_run = 0;
  int ncmd = 0;
  int nsave = 0;
  int cyc = 0;
  logic ext = 1'b1;
  logic [1:0] mode_stored = 2'h1;
  // Short bit time keeps the run to a few thousand cycles
  localparam int unsigned TB_BIT_CYC = 16;

  always #2 clk = ~clk;

  smcp_port #(.BIT_CYC_P(TB_BIT_CYC)) smcp_port_i (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .RXD_I(rxd), .TXD_O(txd),
    .READY_O(ready), .CMD_VALID_O(cmd_valid), .CMD_CLASS_O(cmd_class), .CMD_CODE_O(cmd_code),
    .CMD_FIELD0_O(fld[0]), .CMD_FIELD1_O(fld[1]), .CMD_FIELD2_O(fld[2]),
    .CMD_FIELD3_O(fld[3]), .CMD_FIELD4_O(fld[4]), .CMD_FIELD5_O(fld[5]),
    .CMD_NFIELDS_O(nf), .TASK_DONE_I(task_done), .REPLY_DATA_I(rdata),
    .REPLY_VALID_I(rvalid), .REPLY_SEP_I(rsep), .REPLY_LAST_I(rlast),
    .REPLY_READY_O(rready), .MODE_STORED_I(mode_stored), .MODE_WE_I(mode_we),
    .MODE_I(mode_in), .MODE_SAVE_O(mode_save), .MODE_O(mode_o), .EXTENDED_I(ext),
    .SEQ_LIMIT_O(seq_lim));

  smcp_host #(.BIT_CYC_P(TB_BIT_CYC)) smcp_host_i (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) ncmd++;
    if (mode_save === 1'b1) nsave++;
  end

  // Scenarios take about 5000 cycles; the ceiling leaves fourfold margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_done();
    task_done = 1'b1;
    step(1);
    task_done = 1'b0;
  endtask

  // Holds valid and its qualifiers until an edge samples ready high
  task automatic put_reply(input logic [7:0] d, input logic s, input logic l);
    int n;
    n = 0;
    rdata = d;
    rsep = s;
    rlast = l;
    rvalid = 1'b1;
    @(posedge clk);
    while (rready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("reply taken", 24'h1, 24'(rready));
    #1;
  endtask

  task automatic t_reset();
    step(12);
    chk("txd in reset", 24'h1, 24'(txd));
    chk("ready in reset", 24'h0, 24'(ready));
    rst_n = 1'b1;
    step(3);
    chk("mode restored", 24'h1, 24'(mode_o));
    chk("seq limit", 24'd25, 24'(seq_lim));
    chk("ready idle", 24'h1, 24'(ready));
  endtask

  task automatic t_move();
    logic [23:0] exp [5];
    exp = '{24'd1000, 24'd20, 24'd6, 24'd5, 24'd0};
    smcp_host_i.send_cmd("IE1000,20,6,5,0");
    chk("issued", 24'd1, 24'(ncmd));
    chk("class", 24'(SMCP_IMMED), 24'(cmd_class));
    chk("code", 24'h45, 24'(cmd_code));
    for (int i = 0; i < 5; i++) chk("field", exp[i], fld[i]);
    chk("nfields", 24'd5, 24'(nf));
    chk("unused field", 24'h0, fld[5]);
    chk("ready busy", 24'h0, 24'(ready));
  endtask

  // Second frame while busy is kept, third is dropped
  task automatic t_busy();
    smcp_host_i.send_cmd("CF");
    smcp_host_i.send_cmd("PG");
    chk("no issue busy", 24'd1, 24'(ncmd));
    pulse_done();
    step(2);
    chk("pending run", 24'd2, 24'(ncmd));
    chk("class", 24'(SMCP_SETUP), 24'(cmd_class));
    chk("code", 24'h46, 24'(cmd_code));
    chk("nfields", 24'd1, 24'(nf));
    chk("empty field", 24'h0, fld[0]);
  endtask

  task automatic t_reply();
    logic [7:0] exp [5];
    exp = '{CH_LBRACK, 8'h31, CH_SEMI, 8'h32, CH_RBRACK};
    put_reply(8'h31, 1'b0, 1'b0);
    put_reply(8'h00, 1'b1, 1'b0);
    put_reply(8'h32, 1'b0, 1'b1);
    rvalid = 1'b0;
    for (int i = 0; i < 4000 && smcp_host_i.rx_q.size() < 5; i++) @(posedge clk);
    step(1);
    chk("reply len", 24'd5, 24'(smcp_host_i.rx_q.size()));
    foreach (exp[i]) chk("reply byte", 24'(exp[i]), 24'(smcp_host_i.rx_q[i]));
    // Permission is spent: an unasked reply must not start a frame
    rvalid = 1'b1;
    step(200);
    chk("unasked idle", 24'h1, 24'(txd));
    chk("unasked none", 24'd5, 24'(smcp_host_i.rx_q.size()));
    rvalid = 1'b0;
    pulse_done();
    step(4);
    chk("dropped frame", 24'd2, 24'(ncmd));
    chk("ready again", 24'h1, 24'(ready));
  endtask

  task automatic t_mode();
    mode_in = 2'h2;
    mode_we = 1'b1;
    step(1);
    mode_we = 1'b0;
    step(3);
    chk("mode", 24'h2, 24'(mode_o));
    chk("mode save", 24'd1, 24'(nsave));
    // Mid-run reset: written mode is lost, stored copy comes back
    ext = 1'b0;
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(3);
    chk("mode reload", 24'h1, 24'(mode_o));
    chk("seq limit std", 24'h0, 24'(seq_lim));
    chk("ready after reset", 24'h1, 24'(ready));
  endtask

  initial begin
    t_reset();
    t_move();
    t_busy();
    t_reply();
    t_mode();
    test_done();
  end
endmodule // smcp_port_tb

// ==== rtl/smcp_pkg.sv ====
// Shared constants and types of the serial motion command port
package smcp_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD = 19200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned NUM_FIELDS = 6;
  localparam int unsigned MAX_SEQ = 25;
  localparam logic [7:0] CH_LBRACE = 8'h7b;
  localparam logic [7:0] CH_RBRACE = 8'h7d;
  localparam logic [7:0] CH_LBRACK = 8'h5b;
  localparam logic [7:0] CH_RBRACK = 8'h5d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] STEP_MODE_RESET = 3'h0;
  typedef enum logic [1:0] {SMCP_SETUP, SMCP_IMMED, SMCP_INPUT, SMCP_NONE} smcp_class_e;
  typedef logic [23:0] smcp_field_t;
endpackage

// ==== rtl/smcp_port.sv ====
// Serial command front end: receiver, frame parser, busy, reply sender
`timescale 1ns/1ps
// What this block does
// - Replies wrapped in square brackets
// - 19200 baud, 8N1, no flow control
// - Device replies only after received command
// - Letters and digits carried as ASCII
// - Closing brace alone ends a command
// - Numeric fields split at commas
// - Reply values separated by semicolons
// - First letter selects setup/immediate/input class
// - Extended move: code, steps, rates, ramp, mode
// - Commands discarded while busy, bar one
// - One extra command buffered, run afterwards
// - Busy output low when not accepting
// - Operating mode kept across power loss
// - Extended variant stores 25 sequences
module smcp_port
  import smcp_pkg::*;
#(
  // Bit time in clock cycles; a bench may shorten it to keep runs brief
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic READY_O,
  output logic CMD_VALID_O,
  output smcp_pkg::smcp_class_e CMD_CLASS_O,
  output logic [7:0] CMD_CODE_O,
  output logic [23:0] CMD_FIELD0_O,
  output logic [23:0] CMD_FIELD1_O,
  output logic [23:0] CMD_FIELD2_O,
  output logic [23:0] CMD_FIELD3_O,
  output logic [23:0] CMD_FIELD4_O,
  output logic [23:0] CMD_FIELD5_O,
  output logic [2:0] CMD_NFIELDS_O,
  input wire logic TASK_DONE_I,
  input wire logic [7:0] REPLY_DATA_I,
  input wire logic REPLY_VALID_I,
  input wire logic REPLY_SEP_I,
  input wire logic REPLY_LAST_I,
  output logic REPLY_READY_O,
  input wire logic [1:0] MODE_STORED_I,
  input wire logic MODE_WE_I,
  input wire logic [1:0] MODE_I,
  output logic MODE_SAVE_O,
  output logic [1:0] MODE_O,
  input wire logic EXTENDED_I,
  output logic [4:0] SEQ_LIMIT_O
);
  import smcp_pkg::*;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= CH_ZERO && c <= CH_NINE;
  endfunction

  function automatic smcp_class_e classify(input logic [7:0] c);
    case (c)
      CH_C: return SMCP_SETUP;
      CH_I: return SMCP_IMMED;
      CH_P: return SMCP_INPUT;
      default: return SMCP_NONE;
    endcase
  endfunction

  // Receiver, sampled mid-bit; input is taken synchronous to the clock
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} smcp_rx_e;
  smcp_rx_e rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_stb_q;
  wire rx_tick = rx_cnt_q == 16'h0000;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_stb_q <= 1'b0;
    end else begin
      rx_stb_q <= 1'b0;
      rx_cnt_q <= rx_tick ? 16'h0000 : rx_cnt_q - 16'h0001;
      case (rx_st_q)
        RX_IDLE: if (!RXD_I) begin
          rx_st_q <= RX_START;
          rx_cnt_q <= 16'(BIT_CYC_P / 2);
        end
        RX_START: if (rx_tick) begin
          rx_st_q <= RXD_I ? RX_IDLE : RX_DATA;
          // Tick cycle counts as the first of the next bit, so reload one short
          rx_cnt_q <= 16'(BIT_CYC_P - 1);
          rx_bit_q <= 3'h0;
        end
        RX_DATA: if (rx_tick) begin
          rx_sh_q <= {RXD_I, rx_sh_q[7:1]};
          rx_cnt_q <= 16'(BIT_CYC_P - 1);
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'(DATA_BITS - 1)) rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rx_tick) begin
          rx_st_q <= RX_IDLE;
          rx_stb_q <= RXD_I;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Character buffer between receiver and parser
  logic [7:0] ch_data;
  logic ch_valid;
  logic ch_ready;
  logic buf_in_ready;
  smcp_skid u_skid (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .in_data_i(rx_sh_q),
    .in_valid_i(rx_stb_q),
    .in_ready_o(buf_in_ready),
    .out_data_o(ch_data),
    .out_valid_o(ch_valid),
    .out_ready_i(ch_ready)
  );

  // Frame parser
  logic busy_q;
  logic pend_q;
  logic in_frame_q;
  logic first_q;
  logic [2:0] fidx_q;
  smcp_field_t acc_q [NUM_FIELDS];
  smcp_class_e cls_q;
  logic [7:0] code_q;
  smcp_field_t p_acc_q [NUM_FIELDS];
  smcp_class_e p_cls_q;
  logic [7:0] p_code_q;
  logic [2:0] p_n_q;
  // A full frame is kept only if the task slot or the single spare slot is free
  wire slot_free = !(busy_q && pend_q);
  assign ch_ready = 1'b1;
  wire take = ch_valid;
  wire open_f = take && ch_data == CH_LBRACE;
  wire close_f = take && in_frame_q && ch_data == CH_RBRACE;
  wire comma = take && in_frame_q && !first_q && ch_data == CH_COMMA;
  wire digit = take && in_frame_q && !first_q && is_digit(ch_data);
  wire letter = take && in_frame_q && first_q && ch_data != CH_RBRACE;
  wire accept = close_f && slot_free;
  // A frame closing as the task ends runs at once instead of stranding the spare slot
  wire launch_new = accept && (!busy_q || TASK_DONE_I);
  wire to_pend = accept && busy_q && !TASK_DONE_I;
  wire launch_pend = busy_q && TASK_DONE_I && pend_q;
  wire [2:0] nfields = fidx_q + 3'h1;
  logic [23:0] dig_next;
  assign dig_next = 24'(acc_q[fidx_q] * 24'd10) + {20'h0, ch_data[3:0]};

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      in_frame_q <= 1'b0;
      first_q <= 1'b0;
      fidx_q <= 3'h0;
      cls_q <= SMCP_NONE;
      code_q <= 8'h00;
      for (int i = 0; i < NUM_FIELDS; i++) acc_q[i] <= 24'h0;
    end else begin
      if (open_f) begin
        in_frame_q <= 1'b1;
        first_q <= 1'b1;
        fidx_q <= 3'h0;
        for (int i = 0; i < NUM_FIELDS; i++) acc_q[i] <= 24'h0;
      end else if (close_f) begin
        in_frame_q <= 1'b0;
      end else if (letter) begin
        if (cls_q == SMCP_NONE || first_q && code_q == 8'h00) cls_q <= classify(ch_data);
        first_q <= 1'b0;
      end else if (comma && fidx_q != 3'(NUM_FIELDS - 1)) begin
        fidx_q <= fidx_q + 3'h1;
      end else if (digit) begin
        acc_q[fidx_q] <= dig_next;
      end
      if (open_f) cls_q <= SMCP_NONE;
      if (open_f) code_q <= 8'h00;
      // Second letter of the prefix is the code
      if (take && in_frame_q && !first_q && !is_digit(ch_data) && ch_data != CH_COMMA
          && ch_data != CH_RBRACE && code_q == 8'h00) code_q <= ch_data;
    end
  end

  // Busy tracking and command issue
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      p_cls_q <= SMCP_NONE;
      p_code_q <= 8'h00;
      p_n_q <= 3'h0;
      for (int i = 0; i < NUM_FIELDS; i++) p_acc_q[i] <= 24'h0;
      CMD_VALID_O <= 1'b0;
      CMD_CLASS_O <= SMCP_NONE;
      CMD_CODE_O <= 8'h00;
      CMD_NFIELDS_O <= 3'h0;
      CMD_FIELD0_O <= 24'h0;
      CMD_FIELD1_O <= 24'h0;
      CMD_FIELD2_O <= 24'h0;
      CMD_FIELD3_O <= 24'h0;
      CMD_FIELD4_O <= 24'h0;
      CMD_FIELD5_O <= 24'h0;
    end else begin
      CMD_VALID_O <= launch_new || launch_pend;
      if (launch_new) begin
        busy_q <= 1'b1;
        CMD_CLASS_O <= cls_q;
        CMD_CODE_O <= code_q;
        CMD_NFIELDS_O <= nfields;
        CMD_FIELD0_O <= acc_q[0];
        CMD_FIELD1_O <= acc_q[1];
        CMD_FIELD2_O <= acc_q[2];
        CMD_FIELD3_O <= acc_q[3];
        CMD_FIELD4_O <= acc_q[4];
        CMD_FIELD5_O <= acc_q[5];
      end else if (launch_pend) begin
        pend_q <= 1'b0;
        CMD_CLASS_O <= p_cls_q;
        CMD_CODE_O <= p_code_q;
        CMD_NFIELDS_O <= p_n_q;
        CMD_FIELD0_O <= p_acc_q[0];
        CMD_FIELD1_O <= p_acc_q[1];
        CMD_FIELD2_O <= p_acc_q[2];
        CMD_FIELD3_O <= p_acc_q[3];
        CMD_FIELD4_O <= p_acc_q[4];
        CMD_FIELD5_O <= p_acc_q[5];
      end else if (busy_q && TASK_DONE_I) begin
        busy_q <= 1'b0;
      end
      if (to_pend) begin
        pend_q <= 1'b1;
        p_cls_q <= cls_q;
        p_code_q <= code_q;
        p_n_q <= nfields;
        for (int i = 0; i < NUM_FIELDS; i++) p_acc_q[i] <= acc_q[i];
      end
    end
  end

  // Ready pin: high only when idle with a free slot; low otherwise
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) READY_O <= 1'b0;
    else READY_O <= !busy_q && !pend_q && !in_frame_q && buf_in_ready;
  end

  // Operating mode, reloaded from the nonvolatile copy one cycle after reset
  logic loaded_q;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      loaded_q <= 1'b0;
      MODE_O <= MODE_RESET;
      MODE_SAVE_O <= 1'b0;
      SEQ_LIMIT_O <= 5'h00;
    end else begin
      loaded_q <= 1'b1;
      MODE_SAVE_O <= loaded_q && MODE_WE_I;
      if (!loaded_q) MODE_O <= MODE_STORED_I;
      else if (MODE_WE_I) MODE_O <= MODE_I;
      SEQ_LIMIT_O <= EXTENDED_I ? 5'(MAX_SEQ) : 5'h00;
    end
  end

  // Reply sender: [ v ; v ] framing, only for a received command
  typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_BODY, TX_CLOSE, TX_SHIFT} smcp_tx_e;
  smcp_tx_e tx_st_q;
  smcp_tx_e tx_ret_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [15:0] tx_cnt_q;
  logic tx_last_q;
  logic reply_ok_q;
  wire tx_tick = tx_cnt_q == 16'h0000;
  wire [7:0] body_ch = REPLY_SEP_I ? CH_SEMI : REPLY_DATA_I;
  wire tx_to_body = tx_st_q == TX_BODY ? !REPLY_VALID_I
      : tx_st_q == TX_SHIFT && tx_tick && tx_bit_q == 4'ha && tx_ret_q == TX_BODY;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_st_q <= TX_IDLE;
      tx_ret_q <= TX_IDLE;
      tx_sh_q <= 10'h3ff;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
      tx_last_q <= 1'b0;
      reply_ok_q <= 1'b0;
      TXD_O <= 1'b1;
      REPLY_READY_O <= 1'b0;
    end else begin
      REPLY_READY_O <= tx_to_body;
      tx_cnt_q <= tx_tick ? 16'h0000 : tx_cnt_q - 16'h0001;
      case (tx_st_q)
        TX_IDLE: if (REPLY_VALID_I && reply_ok_q) tx_st_q <= TX_OPEN;
        TX_OPEN: begin
          tx_sh_q <= {1'b1, CH_LBRACK, 1'b0};
          tx_ret_q <= TX_BODY;
          tx_st_q <= TX_SHIFT;
          tx_bit_q <= 4'h0;
          tx_cnt_q <= 16'h0000;
        end
        TX_BODY: if (REPLY_VALID_I) begin
          tx_sh_q <= {1'b1, body_ch, 1'b0};
          tx_last_q <= REPLY_LAST_I;
          tx_ret_q <= REPLY_LAST_I ? TX_CLOSE : TX_BODY;
          tx_st_q <= TX_SHIFT;
          tx_bit_q <= 4'h0;
          tx_cnt_q <= 16'h0000;
        end
        TX_CLOSE: begin
          tx_sh_q <= {1'b1, CH_RBRACK, 1'b0};
          tx_ret_q <= TX_IDLE;
          tx_st_q <= TX_SHIFT;
          tx_bit_q <= 4'h0;
          tx_cnt_q <= 16'h0000;
          reply_ok_q <= 1'b0;
        end
        TX_SHIFT: if (tx_tick) begin
          if (tx_bit_q == 4'ha) begin
            tx_st_q <= tx_ret_q;
          end else begin
            TXD_O <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= 16'(BIT_CYC_P - 1);
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
      // Set wins over the clear in the closing state
      if (CMD_VALID_O) reply_ok_q <= 1'b1;
    end
  end

  a_ready_idle: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    READY_O |-> !$past(busy_q) && !$past(pend_q))
    else $error("ready high while busy");
  a_busy_drop: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    busy_q && pend_q && close_f |=> $stable(p_code_q))
    else $error("spare slot overwritten");
  a_pend_run: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    launch_pend |=> CMD_VALID_O && !pend_q)
    else $error("buffered command not issued");
  a_busy_low: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    CMD_VALID_O |-> !READY_O)
    else $error("ready high at command issue");
  a_mode_load: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    $rose(loaded_q) |-> MODE_O == $past(MODE_STORED_I))
    else $error("stored mode not reloaded");
  a_tx_idle: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    tx_st_q == TX_IDLE |-> TXD_O)
    else $error("serial line not idle high");
endmodule // smcp_port

// ==== rtl/smcp_skid.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module smcp_skid (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [7:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [7:0] mem_q [2];
  logic [1:0] cnt_q;
  logic rd_q;
  logic wr_q;
  wire push = in_valid_i && cnt_q != 2'h2;
  wire pop = out_ready_i && cnt_q != 2'h0;
  assign in_ready_o = cnt_q != 2'h2;
  assign out_valid_o = cnt_q != 2'h0;
  assign out_data_o = mem_q[rd_q];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  a_skid_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i) cnt_q <= 2'h2)
    else $error("buffer count out of range");
endmodule // smcp_skid
